/* design/operand_address_resolver.sv */
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/1ns
`default_nettype none
module operand_address_resolver
   import oar_pkg::*;
(
   input wire logic I_CLK,
   input wire logic I_SYS_RST,
   // Register port
   input wire logic [oar_pkg::OAR_RA_W-1:0] I_REG_ADDR,
   input wire logic [oar_pkg::OAR_RD_W-1:0] I_REG_WDATA,
   input wire logic I_REG_WR,
   input wire logic I_REG_RD,
   output logic [oar_pkg::OAR_RD_W-1:0] O_REG_RDATA,
   // Program counter load from the core
   input wire logic I_PC_LOAD,
   input wire logic [14:0] I_PC_VAL,
   output logic [14:0] O_PC,
   // Data operand request
   input wire logic I_DREQ,
   input wire oar_pkg::oar_dmode_t I_DMODE,
   input wire logic [11:0] I_DOPND,
   input wire logic I_DWIDE,
   output logic O_DVALID,
   output logic [11:0] O_DADDR,
   output logic [11:0] O_DADDR_HI,
   output logic [9:0] O_RAM_IDX,
   output logic O_RAM_SEL,
   output logic O_PERIPH_SEL,
   output logic O_DERR,
   // Program operand request
   input wire logic I_PREQ,
   input wire oar_pkg::oar_pmode_t I_PMODE,
   input wire logic [14:0] I_POPND,
   output logic O_PVALID,
   output logic [14:0] O_PADDR,
   output logic O_PERR,
   // Register field decode
   input wire logic I_FREQ,
   input wire logic [2:0] I_PAIR_SEL,
   input wire logic [1:0] I_BIT_SEL,
   output logic O_FVALID,
   output logic [7:0] O_PAIR_ONEHOT,
   output logic O_PAIR_EXPANSION,
   output logic [3:0] O_BIT_MASK,
   // Bank status
   output logic [3:0] O_ACTIVE_BANK,
   output logic [1:0] O_STACK_BANK,
   output logic O_EXTENDED_MODE
);
   import oar_pkg::*;

   // -------------------------------------------------------------
   // State
   // -------------------------------------------------------------
   typedef struct packed {
      logic bank_enable_flag;
      logic extended_mode;
      logic [3:0] bank_select_reg;
      logic [1:0] stack_bank;
      logic [14:0] pc;
      logic [OAR_RD_W-1:0] rdata;
      logic derr_sticky;
      logic perr_sticky;
      logic dvalid;
      logic [11:0] daddr;
      logic [11:0] daddr_hi;
      logic [9:0] ram_idx;
      logic ram_sel;
      logic periph_sel;
      logic derr;
      logic pvalid;
      logic [14:0] paddr;
      logic perr;
      logic fvalid;
      logic [7:0] pair_onehot;
      logic pair_exp;
      logic [3:0] bit_mask;
   } oar_state_t;

   oar_state_t st_ff;
   oar_state_t nxt_st;

   oar_cfg_if cfg ();

   logic [11:0] d_addr;
   logic d_periph;
   logic d_err;
   logic [14:0] p_addr;
   logic p_err;
   logic [3:0] active_bank;

   // -------------------------------------------------------------
   // Configuration seen by the resolvers
   // -------------------------------------------------------------
   assign cfg.bank_en = st_ff.bank_enable_flag;
   assign cfg.bank_sel = st_ff.bank_select_reg;
   assign cfg.ext_mode = st_ff.extended_mode;
   assign cfg.pc = st_ff.pc;

   // Bank used by HL and direct low-half accesses
   assign active_bank = st_ff.bank_enable_flag ?
                        st_ff.bank_select_reg : 4'h0;

   // -------------------------------------------------------------
   // Resolvers
   // -------------------------------------------------------------
   oar_data_res u_data (
      .cfg (cfg),
      .i_mode (I_DMODE),
      .i_opnd (I_DOPND),
      .i_wide (I_DWIDE),
      .o_addr (d_addr),
      .o_periph (d_periph),
      .o_err (d_err)
   );

   oar_prog_res u_prog (
      .cfg (cfg),
      .i_mode (I_PMODE),
      .i_opnd (I_POPND),
      .o_addr (p_addr),
      .o_err (p_err)
   );

   // -------------------------------------------------------------
   // Legal bank select values
   // -------------------------------------------------------------
   function automatic logic bank_legal(input logic [3:0] b);
      bank_legal = (b <= OAR_BANK_MAXRAM) || (b == OAR_BANK_TOP);
   endfunction

   // -------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.dvalid = 1'b0;
      nxt_st.pvalid = 1'b0;
      nxt_st.fvalid = 1'b0;
      nxt_st.rdata = '0;

      // Register reads, data in the next cycle only
      if (I_REG_RD)
      begin
         case (I_REG_ADDR)
            OAR_REG_CTRL:
            begin
               nxt_st.rdata[OAR_CTRL_BE_BIT] = st_ff.bank_enable_flag;
               nxt_st.rdata[OAR_CTRL_EXT_BIT] = st_ff.extended_mode;
            end
            OAR_REG_BANK:
               nxt_st.rdata[3:0] = st_ff.bank_select_reg;
            OAR_REG_STACK:
               nxt_st.rdata[1:0] = st_ff.stack_bank;
            OAR_REG_PC:
               nxt_st.rdata[14:0] = st_ff.pc;
            OAR_REG_STAT:
            begin
               nxt_st.rdata[3:0] = active_bank;
               nxt_st.rdata[OAR_STAT_DERR_BIT] = st_ff.derr_sticky;
               nxt_st.rdata[OAR_STAT_PERR_BIT] = st_ff.perr_sticky;
            end
            default:
               nxt_st.rdata = '0;
         endcase
      end

      // Register writes
      if (I_REG_WR)
      begin
         case (I_REG_ADDR)
            OAR_REG_CTRL:
            begin
               nxt_st.bank_enable_flag = I_REG_WDATA[OAR_CTRL_BE_BIT];
               nxt_st.extended_mode = I_REG_WDATA[OAR_CTRL_EXT_BIT];
               // Leaving extended mode drops the top PC bit
               if (!I_REG_WDATA[OAR_CTRL_EXT_BIT])
                  nxt_st.pc[14] = 1'b0;
            end
            OAR_REG_BANK:
            begin
               // Banks 4-14 do not exist, so such a write is dropped
               if (bank_legal(I_REG_WDATA[3:0]))
                  nxt_st.bank_select_reg = I_REG_WDATA[3:0];
            end
            OAR_REG_STACK:
               nxt_st.stack_bank = I_REG_WDATA[1:0];
            OAR_REG_PC:
            begin
               nxt_st.pc = I_REG_WDATA[14:0];
               if (!st_ff.extended_mode)
                  nxt_st.pc[14] = 1'b0;
            end
            OAR_REG_STAT:
            begin
               // Write one to clear
               if (I_REG_WDATA[OAR_STAT_DERR_BIT])
                  nxt_st.derr_sticky = 1'b0;
               if (I_REG_WDATA[OAR_STAT_PERR_BIT])
                  nxt_st.perr_sticky = 1'b0;
            end
            default:
               nxt_st.derr_sticky = st_ff.derr_sticky;
         endcase
      end

      // Core loads beat a register write in the same cycle
      if (I_PC_LOAD)
      begin
         nxt_st.pc = I_PC_VAL;
         if (!nxt_st.extended_mode)
            nxt_st.pc[14] = 1'b0;
      end

      // Data operand resolution
      if (I_DREQ)
      begin
         nxt_st.dvalid = 1'b1;
         nxt_st.daddr = d_addr;
         nxt_st.daddr_hi = {d_addr[11:1], 1'b1};
         nxt_st.derr = d_err;
         nxt_st.periph_sel = d_periph & ~d_err;
         nxt_st.ram_sel = ~d_periph & ~d_err;
         nxt_st.ram_idx = {d_addr[9:8], d_addr[7:0]};
         // Set wins over a clear in the same cycle
         if (d_err)
            nxt_st.derr_sticky = 1'b1;
      end

      // Program operand resolution
      if (I_PREQ)
      begin
         nxt_st.pvalid = 1'b1;
         nxt_st.paddr = p_addr;
         nxt_st.perr = p_err;
         if (p_err)
            nxt_st.perr_sticky = 1'b1;
      end

      // Register pair and bit field decode
      if (I_FREQ)
      begin
         nxt_st.fvalid = 1'b1;
         nxt_st.pair_onehot = 8'h01 << I_PAIR_SEL;
         nxt_st.pair_exp = I_PAIR_SEL[2];
         nxt_st.bit_mask = 4'h1 << I_BIT_SEL;
      end
   end

   // -------------------------------------------------------------
   // State register
   // -------------------------------------------------------------
   always_ff @(posedge I_CLK)
   begin
      if (I_SYS_RST)
      begin
         st_ff <= '0;
         st_ff.bank_select_reg <= OAR_BANK_RST;
         st_ff.stack_bank <= OAR_STACK_RST;
         st_ff.pc <= OAR_PC_RST;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   // -------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------
   assign O_REG_RDATA = st_ff.rdata;
   assign O_PC = st_ff.pc;
   assign O_DVALID = st_ff.dvalid;
   assign O_DADDR = st_ff.daddr;
   assign O_DADDR_HI = st_ff.daddr_hi;
   assign O_RAM_IDX = st_ff.ram_idx;
   assign O_RAM_SEL = st_ff.ram_sel;
   assign O_PERIPH_SEL = st_ff.periph_sel;
   assign O_DERR = st_ff.derr;
   assign O_PVALID = st_ff.pvalid;
   assign O_PADDR = st_ff.paddr;
   assign O_PERR = st_ff.perr;
   assign O_FVALID = st_ff.fvalid;
   assign O_PAIR_ONEHOT = st_ff.pair_onehot;
   assign O_PAIR_EXPANSION = st_ff.pair_exp;
   assign O_BIT_MASK = st_ff.bit_mask;
   assign O_ACTIVE_BANK = active_bank;
   assign O_STACK_BANK = st_ff.stack_bank;
   assign O_EXTENDED_MODE = st_ff.extended_mode;

endmodule
`default_nettype wire

/* include/oar_pkg.sv */
// Overview of operation
// - Data space is 1024 four-bit RAM words plus a separate peripheral area.
// - Stack area may sit in RAM bank 0, 1, 2 or 3 by a select setting.
// - Bank flag clear: direct low addresses hit bank 0, high ones bank 15.
// - Indirect DE or DL accesses always go to bank 0.
// - Flag-bit operands use bank 15, only FB0H-FBFH and FF0H-FFFH.
// - Peripheral-bit operands use bank 15, only FC0H-FFFH.
// - Direct 8-bit transfers need an even address, paired with the next odd.
// - Block jump joins PC bits 14-12 with 12 bits; upper blocks extended only.
// - Short relative branch reaches PC-15 to PC-1 or PC+2 to PC+16.
// - Short call targets are 11 bits, 0000H to 07FFH.
// - Table vectors lie in 20H-7FH and must be even.
// - Absolute targets span 0000H-3FFFH; the 7FFFH form needs extended mode.
// - Pair operands pick one of eight pairs, four primary, four expansion.
// - Bit operands are 2 bits picking one bit of a 4-bit word.
// - PC is 15 bits; its top bit stays zero in compatible mode.
package oar_pkg;

   // -------------------------------------------------------------
   // Register port
   // -------------------------------------------------------------
   localparam int OAR_RA_W = 4;
   localparam int OAR_RD_W = 16;
   localparam logic [3:0] OAR_REG_CTRL = 4'h0;
   localparam logic [3:0] OAR_REG_BANK = 4'h1;
   localparam logic [3:0] OAR_REG_STACK = 4'h2;
   localparam logic [3:0] OAR_REG_PC = 4'h3;
   localparam logic [3:0] OAR_REG_STAT = 4'h4;
   localparam int OAR_CTRL_BE_BIT = 0;
   localparam int OAR_CTRL_EXT_BIT = 1;
   localparam int OAR_STAT_DERR_BIT = 4;
   localparam int OAR_STAT_PERR_BIT = 5;
   localparam logic [3:0] OAR_BANK_RST = 4'h0;
   localparam logic [1:0] OAR_STACK_RST = 2'h0;
   localparam logic [14:0] OAR_PC_RST = 15'h0000;

   // -------------------------------------------------------------
   // Address map
   // -------------------------------------------------------------
   localparam int OAR_RAM_WORDS = 1024;
   localparam logic [3:0] OAR_BANK_TOP = 4'hF;
   localparam logic [3:0] OAR_BANK_MAXRAM = 4'h3;
   localparam logic [7:0] OAR_FMEM_LO = 8'hFB;
   localparam logic [7:0] OAR_FMEM_HI = 8'hFF;
   localparam logic [5:0] OAR_PMEM_PAGE = 6'h3F;
   localparam logic [14:0] OAR_BLOCK_END = 15'h7F7F;
   localparam logic [14:0] OAR_REL_BACK = 15'h7FF1;
   localparam logic [14:0] OAR_REL_FWD_LO = 15'h0002;
   localparam logic [14:0] OAR_REL_FWD_HI = 15'h0010;
   localparam logic [6:0] OAR_TADDR_LO = 7'h20;

   typedef enum logic [2:0] {
      OAR_D_DIRECT, OAR_D_HL, OAR_D_PAIR, OAR_D_FMEM, OAR_D_PMEM
   } oar_dmode_t;

   typedef enum logic [2:0] {
      OAR_P_ABS14, OAR_P_ABS15, OAR_P_BLOCK, OAR_P_REL, OAR_P_SCALL,
      OAR_P_TABLE
   } oar_pmode_t;

endpackage

/* include/oar_cfg_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface oar_cfg_if;
   logic bank_en;
   logic [3:0] bank_sel;
   logic ext_mode;
   logic [14:0] pc;
   modport src (output bank_en, output bank_sel, output ext_mode,
                output pc);
   modport dst (input bank_en, input bank_sel, input ext_mode, input pc);
endinterface
`default_nettype wire

/* design/oar_data_res.sv */
`timescale 1ns/1ns
`default_nettype none
module oar_data_res
   import oar_pkg::*;
(
   oar_cfg_if.dst cfg,
   input wire oar_pkg::oar_dmode_t i_mode,
   input wire logic [11:0] i_opnd,
   input wire logic i_wide,
   output logic [11:0] o_addr,
   output logic o_periph,
   output logic o_err
);
   import oar_pkg::*;

   logic [3:0] bank;
   logic [7:0] low;

   always_comb
   begin
      bank = 4'h0;
      low = i_opnd[7:0];
      o_err = 1'b0;
      case (i_mode)
         OAR_D_DIRECT:
         begin
            if (cfg.bank_en)
               bank = cfg.bank_sel;
            else
               bank = i_opnd[7] ? OAR_BANK_TOP : 4'h0;
            o_err = i_wide & i_opnd[0];
         end
         OAR_D_HL:
            bank = cfg.bank_en ? cfg.bank_sel : 4'h0;
         OAR_D_PAIR:
            bank = 4'h0;
         OAR_D_FMEM:
         begin
            bank = OAR_BANK_TOP;
            o_err = (i_opnd[11:4] != OAR_FMEM_LO) &&
                    (i_opnd[11:4] != OAR_FMEM_HI);
         end
         OAR_D_PMEM:
         begin
            bank = OAR_BANK_TOP;
            o_err = i_opnd[11:6] != OAR_PMEM_PAGE;
         end
         default:
            o_err = 1'b1;
      endcase
      // Banks 4-14 hold nothing at all
      if (bank > OAR_BANK_MAXRAM && bank != OAR_BANK_TOP)
         o_err = 1'b1;
      o_addr = {bank, low};
      o_periph = (bank == OAR_BANK_TOP) && low[7];
   end
endmodule
`default_nettype wire

/* design/oar_prog_res.sv */
`timescale 1ns/1ns
`default_nettype none
module oar_prog_res
   import oar_pkg::*;
(
   oar_cfg_if.dst cfg,
   input wire oar_pkg::oar_pmode_t i_mode,
   input wire logic [14:0] i_opnd,
   output logic [14:0] o_addr,
   output logic o_err
);
   import oar_pkg::*;

   logic [14:0] diff;

   always_comb
   begin
      diff = i_opnd - cfg.pc;
      o_addr = i_opnd;
      o_err = 1'b0;
      case (i_mode)
         OAR_P_ABS14:
         begin
            o_addr = {1'b0, i_opnd[13:0]};
            o_err = i_opnd[14];
         end
         OAR_P_ABS15:
            o_err = ~cfg.ext_mode;
         OAR_P_BLOCK:
         begin
            o_addr = {cfg.pc[14:12], i_opnd[11:0]};
            o_err = o_addr > OAR_BLOCK_END;
         end
         OAR_P_REL:
            o_err = !((diff >= OAR_REL_BACK) ||
                      (diff >= OAR_REL_FWD_LO &&
                       diff <= OAR_REL_FWD_HI));
         OAR_P_SCALL:
         begin
            o_addr = {4'h0, i_opnd[10:0]};
            o_err = i_opnd[14:11] != 4'h0;
         end
         OAR_P_TABLE:
         begin
            o_addr = {8'h00, i_opnd[6:0]};
            o_err = (i_opnd[14:7] != 8'h00) || i_opnd[0] ||
                    (i_opnd[6:0] < OAR_TADDR_LO);
         end
         default:
            o_err = 1'b1;
      endcase
      // Upper half exists only in extended mode
      if (o_addr[14] && !cfg.ext_mode)
         o_err = 1'b1;
   end
endmodule
`default_nettype wire

/* test/operand_address_resolver_properties.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Port checks of the resolver
// ----------------------------------------
module oar_properties
   import oar_pkg::*;
(
   input wire logic I_CLK,
   input wire logic I_SYS_RST,
   input wire logic I_DREQ,
   input wire oar_pkg::oar_dmode_t I_DMODE,
   input wire logic [11:0] I_DOPND,
   input wire logic I_DWIDE,
   input wire logic O_DVALID,
   input wire logic [11:0] O_DADDR,
   input wire logic [11:0] O_DADDR_HI,
   input wire logic O_RAM_SEL,
   input wire logic O_PERIPH_SEL,
   input wire logic O_DERR,
   input wire logic I_PREQ,
   input wire oar_pkg::oar_pmode_t I_PMODE,
   input wire logic [14:0] I_POPND,
   input wire logic O_PVALID,
   input wire logic O_PERR,
   input wire logic I_FREQ,
   input wire logic [2:0] I_PAIR_SEL,
   input wire logic [1:0] I_BIT_SEL,
   input wire logic O_FVALID,
   input wire logic [7:0] O_PAIR_ONEHOT,
   input wire logic [3:0] O_BIT_MASK,
   input wire logic [14:0] O_PC,
   input wire logic O_EXTENDED_MODE
);
   import oar_pkg::*;

   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_SYS_RST);

   pair_bank_zero_a: assert property (
      I_DREQ && I_DMODE == OAR_D_PAIR |=> O_DADDR[11:8] == 4'h0 && !O_DERR)
      else $error("pair access left bank 0");
   flag_bank_top_a: assert property (
      I_DREQ && I_DMODE == OAR_D_FMEM |=> O_DERR || O_DADDR[11:8] == 4'hF)
      else $error("flag operand outside bank 15");
   periph_window_a: assert property (
      I_DREQ && I_DMODE == OAR_D_PMEM |=> O_DVALID
      && O_DERR == ($past(I_DOPND) < 12'hFC0))
      else $error("peripheral-bit window wrong");
   wide_odd_a: assert property (
      I_DREQ && I_DMODE == OAR_D_DIRECT && I_DWIDE && I_DOPND[0]
      |=> O_DERR && !O_RAM_SEL && !O_PERIPH_SEL)
      else $error("odd wide address accepted");
   odd_partner_a: assert property (
      O_DVALID && !O_DERR |-> O_DADDR_HI == {O_DADDR[11:1], 1'b1})
      else $error("odd partner address wrong");
   periph_route_a: assert property (
      O_DVALID && !O_DERR |-> !(O_RAM_SEL && O_PERIPH_SEL)
      && O_PERIPH_SEL == (O_DADDR[11:8] == 4'hF && O_DADDR[7]))
      else $error("peripheral routing wrong");
   short_call_a: assert property (
      I_PREQ && I_PMODE == OAR_P_SCALL
      |=> O_PVALID && O_PERR == ($past(I_POPND) > 15'h07FF))
      else $error("short call range wrong");
   table_even_a: assert property (
      I_PREQ && I_PMODE == OAR_P_TABLE && I_POPND[0] |=> O_PERR)
      else $error("odd table vector accepted");
   pc_top_zero_a: assert property (
      !O_EXTENDED_MODE |-> !O_PC[14])
      else $error("pc top bit set in compatible mode");
   bit_mask_a: assert property (
      I_FREQ |=> O_FVALID && O_BIT_MASK == 4'h1 << $past(I_BIT_SEL))
      else $error("bit mask wrong");
   pair_onehot_a: assert property (
      I_FREQ |=> O_PAIR_ONEHOT == 8'h01 << $past(I_PAIR_SEL))
      else $error("pair select wrong");

   cover property (O_DVALID && O_PERIPH_SEL);
   cover property (O_PVALID && O_PERR);
   cover property (O_FVALID && O_PAIR_ONEHOT[7]);
endmodule
bind operand_address_resolver oar_properties u_oar_props (.I_CLK,
   .I_SYS_RST, .I_DREQ, .I_DMODE, .I_DOPND, .I_DWIDE, .O_DVALID, .O_DADDR,
   .O_DADDR_HI, .O_RAM_SEL, .O_PERIPH_SEL, .O_DERR, .I_PREQ, .I_PMODE,
   .I_POPND, .O_PVALID, .O_PERR, .I_FREQ, .I_PAIR_SEL, .I_BIT_SEL,
   .O_FVALID, .O_PAIR_ONEHOT, .O_BIT_MASK, .O_PC, .O_EXTENDED_MODE);
`default_nettype wire

/* test/operand_address_resolver_test.sv */
`timescale 1ns/1ns
`default_nettype none
module operand_address_resolver_test;
   import oar_pkg::*;
   logic I_CLK = 0, I_SYS_RST = 1, I_REG_WR = 0, I_REG_RD = 0;
   logic [3:0] I_REG_ADDR = '0;
   logic [15:0] I_REG_WDATA = '0, O_REG_RDATA;
   logic I_PC_LOAD = 0, I_DREQ = 0, I_DWIDE = 0, I_PREQ = 0, I_FREQ = 0;
   logic [14:0] I_PC_VAL = '0, I_POPND = '0, O_PC, O_PADDR;
   oar_dmode_t I_DMODE = OAR_D_DIRECT;
   oar_pmode_t I_PMODE = OAR_P_ABS14;
   logic [11:0] I_DOPND = '0, O_DADDR, O_DADDR_HI;
   logic [2:0] I_PAIR_SEL = '0;
   logic [1:0] I_BIT_SEL = '0, O_STACK_BANK;
   logic O_DVALID, O_RAM_SEL, O_PERIPH_SEL, O_DERR, O_PVALID, O_PERR;
   logic O_FVALID, O_PAIR_EXPANSION, O_EXTENDED_MODE;
   logic [9:0] O_RAM_IDX;
   logic [7:0] O_PAIR_ONEHOT;
   logic [3:0] O_BIT_MASK, O_ACTIVE_BANK, bs_m = '0;
   logic be_m = 0, ext_m = 0;
   logic [14:0] pc_m = '0;
   int bad_count = 0, tests_run = 0;

   operand_address_resolver DUT (.I_CLK, .I_SYS_RST, .I_REG_ADDR,
      .I_REG_WDATA, .I_REG_WR, .I_REG_RD, .O_REG_RDATA, .I_PC_LOAD,
      .I_PC_VAL, .O_PC, .I_DREQ, .I_DMODE, .I_DOPND, .I_DWIDE, .O_DVALID,
      .O_DADDR, .O_DADDR_HI, .O_RAM_IDX, .O_RAM_SEL, .O_PERIPH_SEL, .O_DERR,
      .I_PREQ, .I_PMODE, .I_POPND, .O_PVALID, .O_PADDR, .O_PERR, .I_FREQ,
      .I_PAIR_SEL, .I_BIT_SEL, .O_FVALID, .O_PAIR_ONEHOT, .O_PAIR_EXPANSION,
      .O_BIT_MASK, .O_ACTIVE_BANK, .O_STACK_BANK, .O_EXTENDED_MODE);

   always #5 I_CLK = ~I_CLK;

   // ----------------------------------------
   // Compare, model and bus tasks
   // ----------------------------------------
   task automatic cmp_val(string n, logic [15:0] e, logic [15:0] g);
      tests_run++;
      if (g !== e)
      begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic cmp_flag(string n, logic e, logic g);
      tests_run++;
      if (g !== e)
      begin
         bad_count++;
         $display("CHECK FAILED %s expected %b seen %b", n, e, g);
      end
   endtask

   task automatic tally_and_finish;
      if (bad_count == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   function automatic logic [12:0] exp_d(oar_dmode_t m, logic [11:0] o,
                                          logic w);
      logic [3:0] bk;
      logic e;
      bk = be_m ? bs_m : {4{o[7] && m == OAR_D_DIRECT}};
      if (m == OAR_D_PAIR)
         bk = 4'h0;
      e = m == OAR_D_DIRECT && w && o[0];
      if (m == OAR_D_FMEM)
         e = o[11:4] != 8'hFB && o[11:4] != 8'hFF;
      if (m == OAR_D_PMEM)
         e = o < 12'hFC0;
      return {e, m >= OAR_D_FMEM ? o : {bk, o[7:0]}};
   endfunction

   function automatic logic [15:0] exp_p(oar_pmode_t m, logic [14:0] o);
      logic [14:0] a;
      logic [14:0] d;
      logic e;
      a = (m == OAR_P_BLOCK) ? {pc_m[14:12], o[11:0]} : o;
      d = o - pc_m;
      case (m)
         OAR_P_ABS14: e = o[14];
         OAR_P_ABS15: e = !ext_m;
         OAR_P_BLOCK: e = a > 15'h7F7F;
         OAR_P_REL: e = !(d inside {[2:16]} || d >= 15'h7FF1);
         OAR_P_SCALL: e = o > 15'h07FF;
         default: e = o[0] || o < 15'h20 || o > 15'h7F;
      endcase
      return {e || (a[14] && !ext_m), a};
   endfunction

   task automatic reg_wr(logic [3:0] a, logic [15:0] d);
      @(posedge I_CLK);
      I_REG_WR <= 1;
      I_REG_ADDR <= a;
      I_REG_WDATA <= d;
      @(posedge I_CLK);
      I_REG_WR <= 0;
   endtask

   task automatic reg_rd(logic [3:0] a, logic [15:0] e);
      @(posedge I_CLK);
      I_REG_RD <= 1;
      I_REG_ADDR <= a;
      @(posedge I_CLK);
      I_REG_RD <= 0;
      #1;
      cmp_val("rdata", e, O_REG_RDATA);
   endtask

   // Illegal banks stay out of the model, as the write is dropped
   task automatic set_cfg(logic b, logic [3:0] s, logic x, logic [14:0] p);
      reg_wr(OAR_REG_CTRL, {14'h0, x, b});
      reg_wr(OAR_REG_BANK, {12'h0, s});
      be_m = b;
      ext_m = x;
      if (s <= 4'h3 || s == 4'hF)
         bs_m = s;
      @(posedge I_CLK);
      I_PC_LOAD <= 1;
      I_PC_VAL <= p;
      @(posedge I_CLK);
      I_PC_LOAD <= 0;
      pc_m = x ? p : {1'h0, p[13:0]};
      #1;
      cmp_val("pc", {1'h0, pc_m}, {1'h0, O_PC});
      cmp_val("bank", b ? bs_m : 4'h0, O_ACTIVE_BANK);
   endtask

   task automatic dreq(oar_dmode_t m, logic [11:0] o, logic w);
      logic [12:0] x;
      x = exp_d(m, o, w);
      @(posedge I_CLK);
      I_DREQ <= 1;
      I_DMODE <= m;
      I_DOPND <= o;
      I_DWIDE <= w;
      @(posedge I_CLK);
      I_DREQ <= 0;
      #1;
      cmp_flag("dvalid", 1'h1, O_DVALID);
      cmp_flag("derr", x[12], O_DERR);
      cmp_flag("periph", !x[12] && x[11:7] == 5'h1F, O_PERIPH_SEL);
      cmp_flag("ramsel", !x[12] && x[11:7] != 5'h1F, O_RAM_SEL);
      if (!x[12])
      begin
         cmp_val("daddr", x[11:0], O_DADDR);
         cmp_val("dhi", x[11:0] | 12'h1, O_DADDR_HI);
         if (x[11:10] == 2'h0)
            cmp_val("ramidx", x[9:0], O_RAM_IDX);
      end
   endtask

   task automatic preq(oar_pmode_t m, logic [14:0] o);
      logic [15:0] x;
      x = exp_p(m, o);
      @(posedge I_CLK);
      I_PREQ <= 1;
      I_PMODE <= m;
      I_POPND <= o;
      @(posedge I_CLK);
      I_PREQ <= 0;
      #1;
      cmp_flag("pvalid", 1'h1, O_PVALID);
      cmp_flag("perr", x[15], O_PERR);
      if (!x[15])
         cmp_val("paddr", x[14:0], O_PADDR);
   endtask

   task automatic freq(logic [2:0] p, logic [1:0] b);
      @(posedge I_CLK);
      I_FREQ <= 1;
      I_PAIR_SEL <= p;
      I_BIT_SEL <= b;
      @(posedge I_CLK);
      I_FREQ <= 0;
      #1;
      cmp_flag("fvalid", 1'h1, O_FVALID);
      cmp_val("pair", 8'h01 << p, O_PAIR_ONEHOT);
      cmp_flag("expansion", p[2], O_PAIR_EXPANSION);
      cmp_val("bitmask", 4'h1 << b, O_BIT_MASK);
   endtask

   // ----------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------
   initial
   begin
      void'($urandom(32'hf27d));
      repeat (4) @(posedge I_CLK);
      I_SYS_RST <= 0;
      reg_rd(OAR_REG_STACK, 16'h0);
      reg_wr(OAR_REG_STACK, 16'h3);
      reg_rd(OAR_REG_STACK, 16'h3);
      cmp_val("stack", 2'h3, O_STACK_BANK);
      reg_rd(4'hF, 16'h0);
      set_cfg(1'h1, 4'h2, 1'h0, 15'h7ABC);
      reg_wr(OAR_REG_BANK, 16'h5);
      reg_rd(OAR_REG_BANK, 16'h2);
      reg_rd(OAR_REG_PC, 16'h3ABC);
      reg_wr(OAR_REG_PC, 16'h7456);
      reg_rd(OAR_REG_PC, 16'h3456);
      set_cfg(1'h0, 4'h0, 1'h0, 15'h3000);
      dreq(OAR_D_DIRECT, 12'h085, 1'h0);
      dreq(OAR_D_DIRECT, 12'h07E, 1'h1);
      dreq(OAR_D_DIRECT, 12'h013, 1'h1);
      dreq(OAR_D_FMEM, 12'hFBF, 1'h0);
      dreq(OAR_D_FMEM, 12'hFC0, 1'h0);
      dreq(OAR_D_PMEM, 12'hFBF, 1'h0);
      dreq(OAR_D_PMEM, 12'hFC0, 1'h0);
      preq(OAR_P_BLOCK, 15'h0123);
      preq(OAR_P_REL, 15'h3001);
      preq(OAR_P_REL, 15'h3002);
      preq(OAR_P_REL, 15'h3010);
      preq(OAR_P_REL, 15'h3011);
      preq(OAR_P_REL, 15'h2FF1);
      preq(OAR_P_REL, 15'h2FF0);
      preq(OAR_P_TABLE, 15'h0020);
      preq(OAR_P_TABLE, 15'h0080);
      preq(OAR_P_SCALL, 15'h0800);
      preq(OAR_P_ABS15, 15'h7FFF);
      preq(OAR_P_ABS14, 15'h4000);
      // Both sticky errors were raised above; bank flag clear here
      reg_rd(OAR_REG_STAT, 16'h0030);
      reg_wr(OAR_REG_STAT, 16'h0030);
      reg_rd(OAR_REG_STAT, 16'h0000);
      set_cfg(1'h1, 4'h3, 1'h1, 15'h7123);
      dreq(OAR_D_PAIR, 12'h012, 1'h0);
      dreq(OAR_D_HL, 12'h0F3, 1'h0);
      preq(OAR_P_BLOCK, 15'h0F80);
      preq(OAR_P_BLOCK, 15'h0F7F);
      preq(OAR_P_ABS15, 15'h7FFF);
      // Random bank values include illegal ones to exercise the refusal
      repeat (300)
      begin
         set_cfg(1'($urandom), 4'($urandom), 1'($urandom), 15'($urandom));
         dreq(oar_dmode_t'($urandom % 5), 12'($urandom), 1'($urandom));
         preq(oar_pmode_t'($urandom % 6), 15'($urandom));
         freq(3'($urandom), 2'($urandom));
      end
      tally_and_finish;
   end

   initial
   begin
      repeat (20000) @(posedge I_CLK);
      bad_count++;
      tally_and_finish;
   end
endmodule
`default_nettype wire
